// ==== src/sbp_status_protect.sv ====
// status register, write enable latch and block protection fence
// assumes commands arrive decoded, one per cycle, synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none

// How it works
// RL1: read-status returns the register; write-status loads it through commands.
// RL2: swd set and protect pin low makes status nonvolatile bits read-only.
// RL3: only driving the protect pin high, or a reset that clears swd, leaves the hardware-protected state.
// RL4: top/bottom select 0 fences the top, 1 fences the bottom.
// RL5: four-bit protect level at bits 6 and 4:2; nonzero blocks program and erase in the fenced blocks.
// RL6: write enable latch is cleared at power-up.
// RL7: write, program and erase need the write enable latch set.
// RL8: busy bit reads 1 during write-status, nv-config write, program, erase.
// RL9: chip erase runs only when the protect level is zero.
// RL10: status bit 0 is always the inverse of flag ready.
// RL11: levels 0..8 protect 0,1,2,4,8,16,32,64,64 blocks.
// RL12: levels 9..15 protect 40..64 blocks, from top or from block 0.
// RL13: write-status never changes the busy bit or the latch directly.
module sbp_status_protect #(
    parameter int unsigned OP_CYCLES = sbp_pkg::BUSY_CYCLES
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire sbp_pkg::sbp_cmd_s cmd_i,
    input  wire logic              wp_pin_n_i,
    output var  sbp_pkg::sbp_rsp_s rsp_o,
    output var  logic [7:0]        status_o,
    output var  logic              flag_ready_o,
    output var  logic              array_start_o
);
    import sbp_pkg::*;

    typedef struct packed {
        sbp_state_e        st;
        logic [7:0]        sr;
        logic              flag_ready;
        logic [BUSY_W-1:0] cnt;
        sbp_rsp_s          rsp;
        logic              start;
    } sbp_regs_s;

    // counter ends one short so busy spans exactly OP_CYCLES cycles
    localparam logic [BUSY_W-1:0] OP_LAST = BUSY_W'(OP_CYCLES - 1);

    sbp_regs_s q;
    sbp_regs_s d;

    function automatic logic [3:0] level_of(input logic [7:0] sr);
        level_of = {sr[BIT_BP3], sr[BIT_BP_HI:BIT_BP_LO]};
    endfunction : level_of

    // levels 7, 8 and 15 all fence the whole array
    // RL11 RL12 protected block count
    function automatic logic [CNT_W-1:0] prot_count(input logic [3:0] lvl);
        unique case (lvl)
            4'h0: prot_count = 7'd0;
            4'h1: prot_count = 7'd1;
            4'h2: prot_count = 7'd2;
            4'h3: prot_count = 7'd4;
            4'h4: prot_count = 7'd8;
            4'h5: prot_count = 7'd16;
            4'h6: prot_count = 7'd32;
            4'h7: prot_count = 7'd64;
            4'h8: prot_count = 7'd64;
            4'h9: prot_count = 7'd40;
            4'hA: prot_count = 7'd48;
            4'hB: prot_count = 7'd56;
            4'hC: prot_count = 7'd60;
            4'hD: prot_count = 7'd62;
            4'hE: prot_count = 7'd63;
            4'hF: prot_count = 7'd64;
        endcase
    endfunction : prot_count

    // RL4 RL12 fence: top counts down from the last block
    function automatic logic is_protected(input logic [7:0] sr,
                                          input logic [BLK_W-1:0] blk);
        logic [CNT_W-1:0] n;
        logic [CNT_W-1:0] b;
        n = prot_count(level_of(sr));
        b = {1'b0, blk};
        if (sr[BIT_TBS]) begin
            is_protected = b < n;
        end else begin
            is_protected = b >= (CNT_W'(BLK_COUNT) - n);
        end
    endfunction : is_protected

    logic hw_locked;
    logic blk_prot;

    // pin is a level, so the lock lifts in the same cycle the pin rises
    // RL2 RL3 lock follows the pin; only reset, by clearing swd, also releases it
    assign hw_locked = q.sr[BIT_SWD] & ~wp_pin_n_i;
    assign blk_prot  = is_protected(q.sr, cmd_i.block);

    always_comb begin
        d              = q;
        d.rsp.accepted = 1'b0;
        d.rsp.refused  = 1'b0;
        d.rsp.rd_valid = 1'b0;
        d.start        = 1'b0;
        unique case (q.st)
            ST_READY: begin
                if (cmd_i.valid) begin
                    unique case (cmd_i.op)
                        // RL1 read returns current contents
                        OP_READ_STATUS: begin
                            d.rsp.rd_valid = 1'b1;
                            d.rsp.rd_data  = q.sr;
                            d.rsp.accepted = 1'b1;
                        end
                        OP_WRITE_ENABLE: begin
                            d.sr[BIT_WEL]  = 1'b1;
                            d.rsp.accepted = 1'b1;
                        end
                        OP_WRITE_DIS: begin
                            d.sr[BIT_WEL]  = 1'b0;
                            d.rsp.accepted = 1'b1;
                        end
                        // RL1 RL2 RL7 RL13 only nonvolatile bits load
                        OP_WRITE_STATUS: begin
                            if (q.sr[BIT_WEL] && !hw_locked) begin
                                d.sr = (cmd_i.data & SR_NV_MASK) | (q.sr & ~SR_NV_MASK);
                                d.sr[BIT_WIP]  = 1'b1;
                                d.st           = ST_BUSY;
                                d.rsp.accepted = 1'b1;
                            end else begin
                                d.rsp.refused = 1'b1;
                            end
                        end
                        // refused rather than dropped, so the host sees the fence
                        // RL5 RL7 program and erase fenced by level
                        OP_PROGRAM, OP_BLOCK_ERASE: begin
                            if (q.sr[BIT_WEL] && !blk_prot) begin
                                d.sr[BIT_WIP]  = 1'b1;
                                d.st           = ST_BUSY;
                                d.start        = 1'b1;
                                d.rsp.accepted = 1'b1;
                            end else begin
                                d.rsp.refused = 1'b1;
                            end
                        end
                        // RL9 chip erase only with level zero
                        OP_CHIP_ERASE: begin
                            if (q.sr[BIT_WEL] && level_of(q.sr) == 4'h0) begin
                                d.sr[BIT_WIP]  = 1'b1;
                                d.st           = ST_BUSY;
                                d.start        = 1'b1;
                                d.rsp.accepted = 1'b1;
                            end else begin
                                d.rsp.refused = 1'b1;
                            end
                        end
                        OP_WRITE_NVCFG: begin
                            if (q.sr[BIT_WEL]) begin
                                d.sr[BIT_WIP]  = 1'b1;
                                d.st           = ST_BUSY;
                                d.rsp.accepted = 1'b1;
                            end else begin
                                d.rsp.refused = 1'b1;
                            end
                        end
                    endcase
                end
                d.cnt = '0;
            end
            // status polling stays open while busy; all else is refused
            ST_BUSY: begin
                if (cmd_i.valid) begin
                    if (cmd_i.op == OP_READ_STATUS) begin
                        d.rsp.rd_valid = 1'b1;
                        d.rsp.rd_data  = q.sr;
                        d.rsp.accepted = 1'b1;
                    end else begin
                        d.rsp.refused = 1'b1;
                    end
                end
                // wel drops at op end: every op needs a fresh write enable
                // RL8 busy holds for the whole cycle count
                if (q.cnt == OP_LAST) begin
                    d.st          = ST_READY;
                    d.sr[BIT_WIP] = 1'b0;
                    d.sr[BIT_WEL] = 1'b0;
                    d.cnt         = '0;
                end else begin
                    d.cnt = q.cnt + 1'b1;
                end
            end
        endcase
        // RL10 flag ready mirrors the busy bit
        d.flag_ready = ~d.sr[BIT_WIP];
    end

    // nonvolatile bits also restart at default: no real storage behind them
    // RL6 latch and busy clear at power-up
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q.st         <= ST_READY;
            q.sr         <= SR_NV_DEFAULT;
            q.flag_ready <= 1'b1;
            q.cnt        <= '0;
            q.rsp        <= '0;
            q.start      <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign rsp_o         = q.rsp;
    assign status_o      = q.sr;
    assign flag_ready_o  = q.flag_ready;
    assign array_start_o = q.start;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic cmd_ready;
    assign cmd_ready = cmd_i.valid && q.st == ST_READY;

    a_wsr_hw_lock: assert property ( // RL2
        cmd_ready && cmd_i.op == OP_WRITE_STATUS && hw_locked
        |=> rsp_o.refused && $stable(status_o[7:2]) && !status_o[BIT_WIP])
        else $error("write-status ran while hardware locked");

    a_wsr_pin_free: assert property ( // RL3
        cmd_ready && cmd_i.op == OP_WRITE_STATUS && q.sr[BIT_WEL] && wp_pin_n_i
        |=> rsp_o.accepted && status_o[7:2] == $past(cmd_i.data[7:2]))
        else $error("write-status refused with pin high");

    a_wel_only_wren: assert property ( // RL7
        $rose(status_o[BIT_WEL]) |-> $past(cmd_i.valid && cmd_i.op == OP_WRITE_ENABLE))
        else $error("latch set without write enable");

    a_no_wel_refuse: assert property ( // RL7
        cmd_ready && !q.sr[BIT_WEL] && cmd_i.op inside {OP_PROGRAM, OP_BLOCK_ERASE}
        |=> rsp_o.refused && !array_start_o)
        else $error("array op ran with latch clear");

    a_chip_erase_lvl: assert property ( // RL9
        cmd_ready && cmd_i.op == OP_CHIP_ERASE && level_of(q.sr) != 4'h0
        |=> !array_start_o && !status_o[BIT_WIP])
        else $error("chip erase ran with protection set");

    a_flag_inverse: assert property ( // RL10
        status_o[BIT_WIP] == !flag_ready_o)
        else $error("busy bit not inverse of flag ready");

    a_top_fence: assert property ( // RL12
        cmd_ready && cmd_i.op == OP_PROGRAM && q.sr[BIT_WEL] && !q.sr[BIT_TBS]
        && level_of(q.sr) == 4'h9 && cmd_i.block == 6'd23
        |=> array_start_o)
        else $error("top level nine fenced block 23");

    a_bottom_fence: assert property ( // RL11
        cmd_ready && cmd_i.op inside {OP_PROGRAM, OP_BLOCK_ERASE} && q.sr[BIT_TBS]
        && level_of(q.sr) == 4'h3 && cmd_i.block == 6'd3
        |=> rsp_o.refused)
        else $error("bottom level three let block 3 through");

    a_wsr_keeps_wel: assert property ( // RL13
        cmd_ready && cmd_i.op == OP_WRITE_STATUS && !hw_locked && q.sr[BIT_WEL]
        |=> status_o[BIT_WEL] && status_o[BIT_WIP])
        else $error("write-status changed latch or busy directly");

    a_busy_ends: assert property ( // RL8
        q.st == ST_BUSY && q.cnt == OP_LAST
        |=> !status_o[BIT_WIP] && !status_o[BIT_WEL] ##1 !status_o[BIT_WIP])
        else $error("busy did not end after its cycle count");

    // RL1 read answer
    a_rd_returns_sr: assert property ( // RL1
        cmd_i.valid && cmd_i.op == OP_READ_STATUS
        |=> rsp_o.rd_valid && rsp_o.accepted && rsp_o.rd_data == $past(status_o))
        else $error("read status did not return the register");

    // RL8 busy refusal
    a_busy_refuse: assert property ( // RL8
        cmd_i.valid && q.st == ST_BUSY && cmd_i.op != OP_READ_STATUS
        |=> rsp_o.refused && !rsp_o.accepted && $stable(status_o[7:2]))
        else $error("command taken while busy");

    // RL7 latch gates writes
    a_writes_need_wel: assert property ( // RL7
        cmd_ready && !q.sr[BIT_WEL]
        && cmd_i.op inside {OP_WRITE_STATUS, OP_WRITE_NVCFG, OP_CHIP_ERASE}
        |=> rsp_o.refused && !status_o[BIT_WIP])
        else $error("write ran with latch clear");

    // RL8 start means busy
    a_start_sets_wip: assert property ( // RL8
        array_start_o |-> status_o[BIT_WIP] && !flag_ready_o)
        else $error("array op started without busy");

    // RL8 start is one pulse
    a_start_one_pulse: assert property ( // RL8
        array_start_o |=> !array_start_o)
        else $error("array start held past one cycle");

    c_hw_lock_refuse: cover property (
        cmd_ready && cmd_i.op == OP_WRITE_STATUS && hw_locked);
    c_program_done: cover property (array_start_o ##[1:64] !status_o[BIT_WIP]);
    c_busy_poll: cover property (q.st == ST_BUSY && cmd_i.valid
        && cmd_i.op == OP_READ_STATUS);
    c_chip_erase_run: cover property (
        cmd_ready && cmd_i.op == OP_CHIP_ERASE && q.sr[BIT_WEL] && level_of(q.sr) == 4'h0);
    c_wsr_accept: cover property (cmd_ready && cmd_i.op == OP_WRITE_STATUS && !hw_locked
        && q.sr[BIT_WEL]);

endmodule : sbp_status_protect

`default_nettype wire

// ==== common/sbp_pkg.sv ====
// package for the status register and block protection logic
// assumes one clock domain and commands already decoded from the serial frame
package sbp_pkg;

    // status register field positions
    localparam int unsigned SR_WIDTH     = 8;
    localparam int unsigned BIT_SWD      = 7;
    localparam int unsigned BIT_BP3      = 6;
    localparam int unsigned BIT_TBS      = 5;
    localparam int unsigned BIT_BP_HI    = 4;
    localparam int unsigned BIT_BP_LO    = 2;
    localparam int unsigned BIT_WEL      = 1;
    localparam int unsigned BIT_WIP      = 0;

    // status bits that a write-status command may change
    localparam logic [7:0] SR_NV_MASK    = 8'h00_FC;
    // nonvolatile defaults: writes enabled, top area, no protection
    localparam logic [7:0] SR_NV_DEFAULT = 8'h00_00;

    // array geometry: 64 blocks of 128KB
    localparam int unsigned BLK_COUNT    = 64;
    localparam int unsigned BLK_W        = 6;
    localparam int unsigned CNT_W        = 7;

    // cycles an internal write, program or erase holds the busy bit
    localparam int unsigned BUSY_CYCLES  = 16;
    localparam int unsigned BUSY_W       = 16;

    typedef enum logic [2:0] {
        OP_READ_STATUS  = 3'b000,
        OP_WRITE_STATUS = 3'b001,
        OP_WRITE_ENABLE = 3'b010,
        OP_WRITE_DIS    = 3'b011,
        OP_PROGRAM      = 3'b100,
        OP_BLOCK_ERASE  = 3'b101,
        OP_CHIP_ERASE   = 3'b110,
        OP_WRITE_NVCFG  = 3'b111
    } sbp_op_e;

    typedef enum logic [0:0] {
        ST_READY = 1'b0,
        ST_BUSY  = 1'b1
    } sbp_state_e;

    // one decoded command from the host
    typedef struct packed {
        logic             valid;
        sbp_op_e          op;
        logic [BLK_W-1:0] block;
        logic [7:0]       data;
    } sbp_cmd_s;

    // answer to one command
    typedef struct packed {
        logic       accepted;
        logic       refused;
        logic       rd_valid;
        logic [7:0] rd_data;
    } sbp_rsp_s;

endpackage : sbp_pkg

// ==== verification/sbp_host_model.sv ====
// host controller model: decoded commands and the protect pin
// assumes the device answers at the taking edge, read 1ns after it
`timescale 1ns/1ps
`default_nettype none
module sbp_host_model (
    input  wire logic              clk_i,
    input  wire sbp_pkg::sbp_rsp_s rsp_i,
    output var  sbp_pkg::sbp_cmd_s cmd_o,
    output var  logic              wp_pin_n_o
);
    import sbp_pkg::*;
    initial begin
        cmd_o = '0;
        wp_pin_n_o = 1'b1;
    end
    task automatic set_wp(input logic lvl);
        @(posedge clk_i);
        wp_pin_n_o <= lvl;
    endtask : set_wp
    task automatic issue(input sbp_op_e op, input logic [5:0] blk,
                         input logic [7:0] dat, output sbp_rsp_s r);
        @(posedge clk_i);
        cmd_o <= '{1'b1, op, blk, dat};
        @(posedge clk_i);
        // idle lines keep the op and invert block and data so a stale block or data never matches
        cmd_o <= '{1'b0, op, ~blk, ~dat};
        #1;
        r = rsp_i;
    endtask : issue
endmodule : sbp_host_model
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench for the status and protection block
// assumes the host model issues every command
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sbp_pkg::*;
    // short busy length keeps the run small; must exceed the busy-read spacing
    localparam int OPC = 6;
    logic       clk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    sbp_cmd_s   cmd;
    sbp_rsp_s   rsp, r;
    sbp_op_e    op;
    logic [7:0] st;
    logic       fr, ast, wp_n;
    logic [5:0] b;
    int         n;
    int         fail_count = 0;
    int         samples_checked = 0;
    integer     seed = 32'h9be4_9994;
    always #2 clk_i = ~clk_i;
    sbp_host_model host (.clk_i(clk_i), .rsp_i(rsp), .cmd_o(cmd), .wp_pin_n_o(wp_n));
    sbp_status_protect #(.OP_CYCLES(OPC)) uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd), .wp_pin_n_i(wp_n),
        .rsp_o(rsp), .status_o(st), .flag_ready_o(fr), .array_start_o(ast));
    task automatic complete_run;
        if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    function automatic int cnt(input logic [3:0] l);
        int t [16] = '{0, 1, 2, 4, 8, 16, 32, 64, 64, 40, 48, 56, 60, 62, 63, 64};
        return t[l];
    endfunction : cnt
    function automatic logic prot(input logic [5:0] bk, input logic tb, input logic [3:0] l);
        return tb ? (int'(bk) < cnt(l)) : (int'(bk) >= 64 - cnt(l));
    endfunction : prot
    task automatic wait_rdy;
        n = 0;
        while (st[0] !== 1'b0 && n < 200) begin
            @(posedge clk_i);
            #1;
            n++;
        end
    endtask : wait_rdy
    task automatic run(input sbp_op_e o, input int bk, input int d, input int ok);
        logic bz;
        bz = ok != 0 && !(o inside {OP_READ_STATUS, OP_WRITE_ENABLE, OP_WRITE_DIS});
        host.issue(o, 6'(bk), 8'(d), r);
        check("accepted", r.accepted, ok);
        check("refused", r.refused, !ok);
        check("array_start", ast, ok && o >= OP_PROGRAM && o <= OP_CHIP_ERASE);
        check("busy set", st[0], bz);
        check("flag_ready", fr, !bz);
        if (ok && o == OP_WRITE_STATUS) check("wel kept", st[1], 1'b1);
        if (bz) begin
            wait_rdy();
            check("busy cycles", n, OPC);
        end
    endtask : run
    task automatic set_sr(input logic swd, input logic tb, input logic [3:0] l);
        logic [7:0] v;
        v = {swd, l[3], tb, l[2:0], 2'($random(seed))};
        run(OP_WRITE_ENABLE, 0, 0, 1);
        run(OP_WRITE_STATUS, 0, v, 1);
        run(OP_READ_STATUS, 0, 0, 1);
        check("rd_valid", r.rd_valid, 1'b1);
        check("status read", r.rd_data, {v[7:2], 2'b00});
    endtask : set_sr
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        check("reset status", st, 8'h00);
        check("reset flag", fr, 1'b1);
        run(OP_PROGRAM, 0, 0, 0);
        run(OP_WRITE_NVCFG, 0, 0, 0);
        run(OP_WRITE_ENABLE, 0, 0, 1);
        check("wel set", st[1], 1'b1);
        run(OP_WRITE_DIS, 0, 0, 1);
        run(OP_BLOCK_ERASE, 5, 0, 0);
        run(OP_WRITE_ENABLE, 0, 0, 1);
        run(OP_WRITE_NVCFG, 0, 8'h5a, 1);
        for (int l = 0; l < 16; l++) begin
            for (int tb = 0; tb < 2; tb++) begin
                set_sr(1'b0, tb[0], l[3:0]);
                // fence edge, one below it, then a random block
                for (int k = 0; k < 3; k++) begin
                    b = tb ? 6'(cnt(l)) : 6'(64 - cnt(l));
                    if (k == 1) b = b - 6'd1;
                    if (k == 2) b = 6'($random(seed));
                    op = (k == 2) ? OP_BLOCK_ERASE : OP_PROGRAM;
                    run(OP_WRITE_ENABLE, 0, 0, 1);
                    run(op, b, 8'($random(seed)), !prot(b, tb[0], l[3:0]));
                end
                run(OP_WRITE_ENABLE, 0, 0, 1);
                run(OP_CHIP_ERASE, 0, 0, l == 0);
            end
        end
        set_sr(1'b1, 1'b0, 4'd0);
        host.set_wp(1'b0);
        run(OP_WRITE_ENABLE, 0, 0, 1);
        run(OP_WRITE_STATUS, 0, 8'h00, 0);
        check("locked", st, 8'h82);
        host.set_wp(1'b1);
        set_sr(1'b0, 1'b0, 4'd0);
        run(OP_WRITE_ENABLE, 0, 0, 1);
        host.issue(OP_PROGRAM, 6'd1, 8'd0, r);
        host.issue(OP_WRITE_ENABLE, 6'd0, 8'd0, r);
        check("busy refuse", r.refused, 1'b1);
        host.issue(OP_READ_STATUS, 6'd0, 8'd0, r);
        check("busy read", r.rd_data[0], 1'b1);
        wait_rdy();
        complete_run();
    end
    initial begin
        #200000;
        fail_count++;
        complete_run();
    end
endmodule : testbench
`default_nettype wire
